// ### design/hub_port_pkg.sv
// Purpose: Shared constants and types for the hub downstream port control.
// Assumes: Four downstream ports, registers of up to 8 bits in 32-bit bus words.
// Notes:   Offsets are byte addresses on the register bus.
package hub_port_pkg;
  localparam int          NUM_PORTS      = 4;
  localparam int          ADDR_W         = 5;
  localparam logic [4:0]  OFS_SPEED      = 5'h00;
  localparam logic [4:0]  OFS_ENABLE     = 5'h04;
  localparam logic [4:0]  OFS_FORCE_CTL  = 5'h08;
  localparam logic [4:0]  OFS_FORCE_LOW  = 5'h0c;
  localparam logic [4:0]  OFS_SE0_STATUS = 5'h10;
  localparam logic [4:0]  OFS_PORT_DATA  = 5'h14;
  localparam logic [7:0]  RESET_REG8     = 8'h00;
  localparam logic [3:0]  RESET_REG4     = 4'h0;
  localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;
  // Force field codes, two bits per port.
  localparam logic [1:0]  FORCE_NONE     = 2'h0;
  localparam logic [1:0]  FORCE_DIFF1    = 2'h1;
  localparam logic [1:0]  FORCE_DIFF0    = 2'h2;
  localparam logic [1:0]  FORCE_SE0      = 2'h3;
  // Force-low bit of a port's D+ and D- within the force-low register.
  localparam int          FLOW_DP_OFS    = 1;
  localparam int          FLOW_DM_OFS    = 0;

  typedef struct packed {
    logic [NUM_PORTS-1:0] dPlus;
    logic [NUM_PORTS-1:0] dMinus;
  } linePair_type;
endpackage : hub_port_pkg

// ### design/hub_downstream_port_control.sv
// Purpose: Enable, force and sense logic for four hub downstream ports.
// Assumes: Avalon-MM slave with waitrequest; eof2Tick is a one-cycle pulse
//          from the frame timer on clk; line inputs come from the pins.
// Notes:   Registers hold up to 8 bits in byte lane 0; upper bits read as zero.
// Summary of operation
// - Enables cleared on chip and bus reset.
// - Babble clears that port's enable bit.
// - Babble: non-idle line or connectivity at EOF2.
// - Two-bit force field: normal, differential 1, differential 0, SE0.
// - Force field cleared on reset and bus reset.
// - Forced pins use edge rate of port speed.
// - Per-pin force-low bits, no edge rate control.
// - Force-low still applied during suspend.
// - Data register shows differential state only.
// - SE0 sets status, data holds last state.
// - SE0 status and data cleared on resets.
// - Unused port pins usable as general I/O.
// - Speed bit one means low speed.
// - Enable bit one lets repeater traffic through.
`timescale 1ns/1ns
module hub_downstream_port_control
  import hub_port_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               busReset,
  input  wire logic               eof2Tick,
  input  wire logic [NUM_PORTS-1:0] upstreamLinked,
  input  wire linePair_type       lineIn,
  input  wire logic [ADDR_W-1:0]  address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  input  wire logic [3:0]         byteenable,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  output linePair_type            lineOut,
  output linePair_type            lineOe,
  output linePair_type            edgeRateOn,
  output logic [NUM_PORTS-1:0]    lowSpeedEdge,
  output logic [NUM_PORTS-1:0]    portEnabled
);

  logic [3:0]   speed_reg;
  logic [3:0]   enable_reg;
  logic [7:0]   forceCtl_reg;
  logic [7:0]   forceLow_reg;
  logic [3:0]   se0Status_reg;
  logic [3:0]   portData_reg;
  logic [31:0]  readdata_reg;
  logic         waitrequest_reg;
  linePair_type sync1_reg;
  linePair_type sync2_reg;
  linePair_type sync3_reg;
  linePair_type stable_reg;
  linePair_type lineOut_reg;
  linePair_type lineOe_reg;
  linePair_type edgeRate_reg;
  logic [3:0]   lowSpeed_reg;
  logic [3:0]   babble;
  logic [31:0]  readMux;
  logic         wrTake;
  logic         anyReset;

  // The pin stages wake at full-speed J, the idle level at reset, so no
  // false SE0 is sensed while the first samples travel through.
  localparam linePair_type LINE_IDLE = '{dPlus:  {NUM_PORTS{1'b1}},
                                         dMinus: {NUM_PORTS{1'b0}}};

  assign anyReset = rst | busReset;
  // The write lands at the edge where the master sees waitrequest low.
  assign wrTake   = write & ~waitrequest_reg & byteenable[0];

  // Bus handshake: every access is answered one cycle after it is raised.
  always_ff @(posedge clk)
  begin
    if (rst)
      waitrequest_reg <= 1'b1;
    else if ((read | write) & waitrequest_reg)
      waitrequest_reg <= 1'b0;
    else
      waitrequest_reg <= 1'b1;
  end

  always_comb
  begin
    readMux = READ_UNMAPPED;
    case (address)
      OFS_SPEED:      readMux = {28'h0000000, speed_reg};
      OFS_ENABLE:     readMux = {28'h0000000, enable_reg};
      OFS_FORCE_CTL:  readMux = {24'h000000, forceCtl_reg};
      OFS_FORCE_LOW:  readMux = {24'h000000, forceLow_reg};
      OFS_SE0_STATUS: readMux = {28'h0000000, se0Status_reg};
      OFS_PORT_DATA:  readMux = {28'h0000000, portData_reg};
      default:        readMux = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      readdata_reg <= READ_UNMAPPED;
    else if (read & waitrequest_reg)
      readdata_reg <= readMux;
  end

  always_ff @(posedge clk)
  begin
    if (anyReset)
      speed_reg <= RESET_REG4;
    else if (wrTake && address == OFS_SPEED)
      speed_reg <= writedata[3:0];
  end

  // Babble clears are applied after a same-cycle firmware write, so a
  // babbling port can never be re-enabled by a racing write.
  always_ff @(posedge clk)
  begin
    if (anyReset)
      enable_reg <= RESET_REG4;
    else if (wrTake && address == OFS_ENABLE)
      enable_reg <= writedata[3:0] & ~babble;
    else
      enable_reg <= enable_reg & ~babble;
  end

  always_ff @(posedge clk)
  begin
    if (anyReset)
      forceCtl_reg <= RESET_REG8;
    else if (wrTake && address == OFS_FORCE_CTL)
      forceCtl_reg <= writedata[7:0];
  end

  // Force-low survives bus reset so pins stay low through suspend.
  always_ff @(posedge clk)
  begin
    if (rst)
      forceLow_reg <= RESET_REG8;
    else if (wrTake && address == OFS_FORCE_LOW)
      forceLow_reg <= writedata[7:0];
  end

  // Three-stage pin synchroniser; stable_reg moves only when the second
  // and third stages agree, filtering single-cycle glitches.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg  <= LINE_IDLE;
      sync2_reg  <= LINE_IDLE;
      sync3_reg  <= LINE_IDLE;
      stable_reg <= LINE_IDLE;
    end
    else
    begin
      sync1_reg <= lineIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg)
        stable_reg <= sync3_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_PORTS; i++)
    begin : g_port
      logic       idleJ;
      logic       isSe0;
      logic [1:0] fc;
      logic       flDp;
      logic       flDm;
      assign fc    = forceCtl_reg[2*i+1:2*i];
      assign flDp  = forceLow_reg[2*i+FLOW_DP_OFS];
      assign flDm  = forceLow_reg[2*i+FLOW_DM_OFS];
      assign isSe0 = ~stable_reg.dPlus[i] & ~stable_reg.dMinus[i];
      // Idle is J: D+ high for full speed, D- high for low speed.
      assign idleJ = speed_reg[i]
                   ? (~stable_reg.dPlus[i] & stable_reg.dMinus[i])
                   : (stable_reg.dPlus[i] & ~stable_reg.dMinus[i]);
      assign babble[i] = eof2Tick & enable_reg[i]
                       & (~idleJ | upstreamLinked[i]);

      always_ff @(posedge clk)
      begin
        if (anyReset)
        begin
          se0Status_reg[i] <= 1'b0;
          portData_reg[i]  <= 1'b0;
        end
        else
        begin
          se0Status_reg[i] <= isSe0;
          if (!isSe0)
            portData_reg[i] <= stable_reg.dPlus[i];
        end
      end

      // Force-low wins per pin; it has no edge rate control.
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          lineOut_reg.dPlus[i]   <= 1'b0;
          lineOut_reg.dMinus[i]  <= 1'b0;
          lineOe_reg.dPlus[i]    <= 1'b0;
          lineOe_reg.dMinus[i]   <= 1'b0;
          edgeRate_reg.dPlus[i]  <= 1'b0;
          edgeRate_reg.dMinus[i] <= 1'b0;
          lowSpeed_reg[i]        <= 1'b0;
        end
        else
        begin
          lowSpeed_reg[i]        <= speed_reg[i];
          lineOe_reg.dPlus[i]    <= flDp | (fc != FORCE_NONE);
          lineOe_reg.dMinus[i]   <= flDm | (fc != FORCE_NONE);
          lineOut_reg.dPlus[i]   <= ~flDp & (fc == FORCE_DIFF1);
          lineOut_reg.dMinus[i]  <= ~flDm & (fc == FORCE_DIFF0);
          edgeRate_reg.dPlus[i]  <= ~flDp & (fc != FORCE_NONE);
          edgeRate_reg.dMinus[i] <= ~flDm & (fc != FORCE_NONE);
        end
      end
    end
  endgenerate

  assign readdata     = readdata_reg;
  assign waitrequest  = waitrequest_reg;
  assign lineOut      = lineOut_reg;
  assign lineOe       = lineOe_reg;
  assign edgeRateOn   = edgeRate_reg;
  assign lowSpeedEdge = lowSpeed_reg;
  assign portEnabled  = enable_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_resetClearsEnable;
    busReset |=> (enable_reg == 4'h0) && (forceCtl_reg == 8'h00);
  endproperty
  a_resetClearsEnable: assert property (p_resetClearsEnable)
    else $error("Enables or force field not cleared by bus reset.");

  property p_babbleDisables;
    (eof2Tick && enable_reg[0] && upstreamLinked[0] && !busReset)
      |=> !portEnabled[0];
  endproperty
  a_babbleDisables: assert property (p_babbleDisables)
    else $error("Babbling port stayed enabled.");

  property p_noBabbleNoClear;
    (!eof2Tick && !busReset && !(write && !waitrequest_reg))
      |=> (enable_reg == $past(enable_reg));
  endproperty
  a_noBabbleNoClear: assert property (p_noBabbleNoClear)
    else $error("Enable changed without write or EOF2.");

  property p_forceSe0;
    (forceCtl_reg[1:0] == FORCE_SE0 && forceLow_reg[1:0] == 2'h0)
      |=> lineOe.dPlus[0] && !lineOut.dPlus[0] && !lineOut.dMinus[0];
  endproperty
  a_forceSe0: assert property (p_forceSe0)
    else $error("SE0 force not driven on port one.");

  property p_forceJ;
    (forceCtl_reg[3:2] == FORCE_DIFF1 && forceLow_reg[3:2] == 2'h0)
      |=> lineOut.dPlus[1] && !lineOut.dMinus[1] && edgeRateOn.dPlus[1];
  endproperty
  a_forceJ: assert property (p_forceJ)
    else $error("Differential one force wrong on port two.");

  property p_forceLowPin;
    forceLow_reg[7] |=> lineOe.dPlus[3] && !lineOut.dPlus[3]
                        && !edgeRateOn.dPlus[3];
  endproperty
  a_forceLowPin: assert property (p_forceLowPin)
    else $error("Force-low pin not held low without edge control.");

  property p_forceLowHeld;
    (busReset && !wrTake) |=> forceLow_reg == $past(forceLow_reg);
  endproperty
  a_forceLowHeld: assert property (p_forceLowHeld)
    else $error("Force-low lost on bus reset.");

  logic isSe0Port0;
  assign isSe0Port0 = ~stable_reg.dPlus[0] & ~stable_reg.dMinus[0];

  property p_se0Hold;
    (!busReset && isSe0Port0 && !$past(isSe0Port0, 1))
      |=> se0Status_reg[0] && portData_reg[0] == $past(portData_reg[0]);
  endproperty
  a_se0Hold: assert property (p_se0Hold)
    else $error("SE0 entry did not hold data or set status.");

  property p_se0Clear;
    busReset |=> se0Status_reg == 4'h0 && portData_reg == 4'h0;
  endproperty
  a_se0Clear: assert property (p_se0Clear)
    else $error("SE0 status or data not cleared by bus reset.");

  property p_busAnswer;
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest;
  endproperty
  a_busAnswer: assert property (p_busAnswer)
    else $error("Bus access not answered in one cycle.");

  c_babble:   cover property (eof2Tick && |babble);
  c_forceSe0: cover property (forceCtl_reg == 8'hff);
  c_se0Seen:  cover property (se0Status_reg != 4'h0);
  c_readBack: cover property (read && !waitrequest);

endmodule : hub_downstream_port_control

// ### bench/usb_dev_model.sv
// Purpose: Downstream USB devices seen at the four port pin pairs.
// Assumes: Each device drives its pins whenever the hub does not.
// Notes:   The bench sets what each device drives through devDrive.
`timescale 1ns/1ns
module usb_dev_model
  import hub_port_pkg::*;
(
  input  wire linePair_type lineOut,
  input  wire linePair_type lineOe,
  input  wire linePair_type devDrive,
  output linePair_type      lineIn
);
  // The wire shows the hub where it drives, else the device's own level.
  assign lineIn = linePair_type'((lineOe & lineOut) | (~lineOe & devDrive));
endmodule : usb_dev_model

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the downstream port control block.
// Assumes: One wait cycle per bus access; pins settle within 8 cycles.
// Notes:   Full-speed J idle is D+ high, D- low on every device.
`timescale 1ns/1ns
module tb_top
  import hub_port_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, busReset = 1'b0, eof2Tick = 1'b0;
  logic read = 1'b0, write = 1'b0, waitrequest;
  logic [3:0] upstreamLinked = 4'h0, byteenable = 4'hf, lowSpeedEdge;
  logic [3:0] portEnabled;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, rd;
  linePair_type lineIn, lineOut, lineOe, edgeRateOn;
  linePair_type devDrive = '{dPlus: 4'hf, dMinus: 4'h0};
  int fails = 0, tests_run = 0;
  always #25 clk = ~clk;
  hub_downstream_port_control hub_downstream_port_control_i (.clk(clk),
    .rst(rst), .busReset(busReset), .eof2Tick(eof2Tick),
    .upstreamLinked(upstreamLinked), .lineIn(lineIn), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .lineOut(lineOut), .lineOe(lineOe),
    .edgeRateOn(edgeRateOn), .lowSpeedEdge(lowSpeedEdge),
    .portEnabled(portEnabled));
  usb_dev_model usb_dev_model_i (.lineOut(lineOut), .lineOe(lineOe),
    .devDrive(devDrive), .lineIn(lineIn));
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low, then releases it.
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    if (wr)
      write <= 1'b1;
    else
      read <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    if (waitrequest !== 1'b0)
    begin
      fails++;
      wrap_up();
    end
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task rchk(input string what, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask : rchk
  // Raises eof2Tick or busReset for one cycle, then lets the pins settle.
  task strobe(input logic eof, input logic brst);
    eof2Tick <= eof;
    busReset <= brst;
    @(posedge clk);
    eof2Tick <= 1'b0;
    busReset <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : strobe
  task t_reset;
    // Read first, while the pin stages still hold their reset level.
    rchk("se0 status", OFS_SE0_STATUS, 32'h0);
    rchk("speed", OFS_SPEED, 32'h0);
    rchk("enable", OFS_ENABLE, 32'h0);
    rchk("forcectl", OFS_FORCE_CTL, 32'h0);
    rchk("forcelow", OFS_FORCE_LOW, 32'h0);
    rchk("unmapped", 5'h18, 32'h0);
    $display("test reset values done");
  endtask : t_reset
  task t_babble;
    bus(1'b1, OFS_ENABLE, 32'hf);
    chk("enabled", 32'hf, portEnabled);
    strobe(1'b1, 1'b0);
    chk("idle eof2", 32'hf, portEnabled);
    chk("idle no drive", 32'h0, lineOe);
    rchk("data reg", OFS_PORT_DATA, 32'hf);
    devDrive.dPlus[2] <= 1'b0;
    repeat (8) @(posedge clk);
    rchk("se0 status", OFS_SE0_STATUS, 32'h4);
    rchk("data held", OFS_PORT_DATA, 32'hf);
    strobe(1'b1, 1'b0);
    chk("line babble", 32'hb, portEnabled);
    upstreamLinked <= 4'h1;
    strobe(1'b1, 1'b0);
    upstreamLinked <= 4'h0;
    chk("linked babble", 32'ha, portEnabled);
    rchk("enable reg", OFS_ENABLE, 32'ha);
    // Bus reset is held over the reads: once it drops, the live pin
    // state refills the status and data registers.
    busReset <= 1'b1;
    devDrive.dPlus[2] <= 1'b1;
    @(posedge clk);
    rchk("se0 cleared", OFS_SE0_STATUS, 32'h0);
    rchk("data cleared", OFS_PORT_DATA, 32'h0);
    chk("bus reset en", 32'h0, portEnabled);
    busReset <= 1'b0;
    $display("test babble done");
  endtask : t_babble
  task t_force;
    logic [7:0] c;
    logic [3:0] p, m;
    bus(1'b1, OFS_ENABLE, 32'h0);
    bus(1'b1, OFS_SPEED, 32'h5);
    for (int k = 0; k < 4; k++)
    begin
      c = {4{k[1:0]}};
      p = (k == 1) ? 4'hf : 4'h0;
      m = (k == 2) ? 4'hf : 4'h0;
      bus(1'b1, OFS_FORCE_CTL, {24'h0, c});
      repeat (2) @(posedge clk);
      chk("oe", (k == 0) ? 32'h0 : 32'hff, lineOe);
      chk("edge", (k == 0) ? 32'h0 : 32'hff, edgeRateOn);
      chk("low speed", 32'h5, lowSpeedEdge);
      if (k != 0)
        chk("out", {24'h0, p, m}, lineOut);
    end
    bus(1'b1, OFS_FORCE_CTL, 32'h55);
    byteenable <= 4'he;
    bus(1'b1, OFS_FORCE_LOW, 32'hff);
    byteenable <= 4'hf;
    rchk("lane off", OFS_FORCE_LOW, 32'h0);
    bus(1'b1, OFS_FORCE_LOW, 32'h80);
    repeat (2) @(posedge clk);
    chk("flow out", 32'h70, lineOut);
    chk("flow edge", 32'h7f, edgeRateOn);
    strobe(1'b0, 1'b1);
    chk("flow oe", 32'h80, lineOe);
    chk("flow edge2", 32'h0, edgeRateOn);
    rchk("ctl cleared", OFS_FORCE_CTL, 32'h0);
    rchk("flow kept", OFS_FORCE_LOW, 32'h80);
    // Unconfigured hubs hold SE0 with every pin forced low; the wait
    // lets the forced level come back through the pin synchroniser.
    bus(1'b1, OFS_FORCE_LOW, 32'hff);
    repeat (8) @(posedge clk);
    chk("se0 out", 32'h0, lineOut);
    chk("se0 oe", 32'hff, lineOe);
    rchk("pins sensed", OFS_SE0_STATUS, 32'hf);
    bus(1'b1, OFS_FORCE_LOW, 32'h0);
    $display("test force done");
  endtask : t_force
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_babble();
    t_force();
    wrap_up();
  end
endmodule : tb_top
